/* File: shared/pcht_pkg.sv */
// package with config-tail register map, field layout and port carriers
package pcht_pkg;

	// ----------------------------------------
	// register indices (config dword index) and byte addresses
	// ----------------------------------------
	localparam logic [5:0] IDX_RESERVED_A = 6'hC;
	localparam logic [5:0] IDX_CAP_PTR = 6'hD;
	localparam logic [5:0] IDX_RESERVED_B = 6'hE;
	localparam logic [5:0] IDX_LAT_GNT_INT = 6'hF;
	localparam logic [7:0] ADDR_RESERVED_A = 8'h30;
	localparam logic [7:0] ADDR_CAP_PTR = 8'h34;
	localparam logic [7:0] ADDR_RESERVED_B = 8'h38;
	localparam logic [7:0] ADDR_LAT_GNT_INT = 8'h3C;

	// ----------------------------------------
	// field values
	// ----------------------------------------
	localparam logic [7:0] CAP_OFFSET = 8'h40;
	localparam logic [7:0] MAX_LATENCY = 8'h00;
	localparam logic [7:0] MIN_GRANT = 8'h00;
	localparam logic [7:0] INT_PIN_INTA = 8'h01;
	localparam logic [7:0] INT_LINE_RESET = 8'h00;
	localparam logic [23:0] ZERO_UPPER = 24'h000000;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam int LINE_LSB = 0;
	localparam int LINE_MSB = 7;
	localparam int LANE_LINE = 0;
	localparam int UPPER_LSB = 8;
	localparam int PIN_LSB = 8;
	localparam int PIN_MSB = 15;
	localparam int GNT_LSB = 16;
	localparam int GNT_MSB = 23;
	localparam int LAT_LSB = 24;
	localparam int LAT_MSB = 31;
	localparam logic [31:0] LGI_RESET = 32'h00000100;

	// ----------------------------------------
	// word select positions
	// ----------------------------------------
	localparam int SEL_RESERVED_A = 0;
	localparam int SEL_CAP_PTR = 1;
	localparam int SEL_RESERVED_B = 2;
	localparam int SEL_LAT_GNT_INT = 3;

	// ----------------------------------------
	// port carriers
	// ----------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] idx;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcht_req_t;

	typedef struct packed {
		logic [7:0] int_line;
		logic [31:0] pci_rdata;
		logic [31:0] periph_rdata;
	} pcht_state_t;

	localparam pcht_state_t STATE_RESET = '{
		int_line: INT_LINE_RESET,
		pci_rdata: ZERO_WORD,
		periph_rdata: ZERO_WORD
	};

endpackage

/* File: core/pcht_regs.sv */
// config header tail: reserved words, capability pointer, latency/grant/interrupt word
`timescale 1ns/1ns
module pcht_regs (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// pci configuration port
	input wire pcht_pkg::pcht_req_t pci_req_i,
	output logic [31:0] pci_rdata_o,
	// peripheral bus port
	input wire pcht_pkg::pcht_req_t periph_req_i,
	output logic [31:0] periph_rdata_o,
	// current interrupt line value
	output logic [7:0] int_line_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	pcht_pkg::pcht_state_t state_q;
	pcht_pkg::pcht_state_t state_d;

	// ----------------------------------------
	// per-port decode
	// ----------------------------------------
	logic [3:0] pci_sel;
	logic [3:0] periph_sel;
	logic pci_line_we;
	logic periph_line_we;
	logic [31:0] pci_word;
	logic [31:0] periph_word;

	pcht_port_dec u_pcht_port_dec_pci (
		.req_i(pci_req_i),
		.line_i(state_q.int_line),
		.sel_o(pci_sel),
		.line_we_o(pci_line_we),
		.word_o(pci_word)
	);

	pcht_port_dec u_pcht_port_dec_periph (
		.req_i(periph_req_i),
		.line_i(state_q.int_line),
		.sel_o(periph_sel),
		.line_we_o(periph_line_we),
		.word_o(periph_word)
	);

	function automatic logic hits_line(input pcht_pkg::pcht_req_t r);
		return r.wr && (r.idx == pcht_pkg::IDX_LAT_GNT_INT) && r.be[pcht_pkg::LANE_LINE];
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		// other bits and words have no storage, so writes there fall away
		if (pci_line_we) begin
			state_d.int_line = pci_req_i.wdata[pcht_pkg::LINE_MSB:pcht_pkg::LINE_LSB];
		end else if (periph_line_we) begin
			state_d.int_line = periph_req_i.wdata[pcht_pkg::LINE_MSB:pcht_pkg::LINE_LSB];
		end
		// read data holds until the next read on that port; a read beside a write sees the old line
		if (pci_req_i.rd) begin
			state_d.pci_rdata = pci_word;
		end
		if (periph_req_i.rd) begin
			state_d.periph_rdata = periph_word;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_q <= pcht_pkg::STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign pci_rdata_o = state_q.pci_rdata;
	assign periph_rdata_o = state_q.periph_rdata;
	assign int_line_o = state_q.int_line;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	rsvd_reads_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && (pci_req_i.idx == pcht_pkg::IDX_RESERVED_A
			|| pci_req_i.idx == pcht_pkg::IDX_RESERVED_B) |=> pci_rdata_o == 32'h00000000)
		else $error("reserved word read nonzero");
	cap_ptr_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_req_i.idx == pcht_pkg::IDX_CAP_PTR
			|=> periph_rdata_o == 32'h00000040)
		else $error("capability pointer read wrong");
	cap_ptr_upper_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_CAP_PTR |=> pci_rdata_o[31:8] == 24'h0)
		else $error("capability pointer upper bits nonzero");
	upper_fixed_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
			|=> pci_rdata_o[31:16] == 16'h0000)
		else $error("latency or grant field nonzero");
	int_pin_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
			|=> periph_rdata_o[15:8] == 8'h01)
		else $error("interrupt pin not INTA");
	line_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		hits_line(periph_req_i) && !hits_line(pci_req_i)
			|=> int_line_o == $past(periph_req_i.wdata[7:0]))
		else $error("peripheral line write lost");
	pci_wins_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		hits_line(pci_req_i) |=> int_line_o == $past(pci_req_i.wdata[7:0]))
		else $error("pci line write lost");
	line_holds_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!hits_line(pci_req_i) && !hits_line(periph_req_i) |=> $stable(int_line_o))
		else $error("line changed without write");
	line_readback_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
			|=> pci_rdata_o[7:0] == $past(int_line_o))
		else $error("line readback wrong");
	reset_value_a: assert property (@(posedge core_clk_i)
		$past(rst_i) |-> int_line_o == 8'h00)
		else $error("line reset value wrong");


	// ----------------------------------------
	// reserved and unmapped words
	// ----------------------------------------
	rsvd_periph_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && (periph_req_i.idx == pcht_pkg::IDX_RESERVED_A
			|| periph_req_i.idx == pcht_pkg::IDX_RESERVED_B)
		|=> periph_rdata_o == pcht_pkg::ZERO_WORD)
		else $error("reserved word read nonzero on peripheral port");

	pci_unmapped_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_sel == '0
		|=> pci_rdata_o == pcht_pkg::ZERO_WORD)
		else $error("unmapped pci read nonzero");

	periph_unmapped_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_sel == '0
		|=> periph_rdata_o == pcht_pkg::ZERO_WORD)
		else $error("unmapped peripheral read nonzero");

	pci_sel_single_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd |-> $onehot0(pci_sel))
		else $error("pci decode hit two words");

	periph_sel_single_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd |-> $onehot0(periph_sel))
		else $error("peripheral decode hit two words");

	// ----------------------------------------
	// capability pointer
	// ----------------------------------------
	cap_ptr_pci_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_CAP_PTR
		|=> pci_rdata_o == {pcht_pkg::ZERO_UPPER, pcht_pkg::CAP_OFFSET})
		else $error("capability pointer read wrong on pci port");

	cap_upper_periph_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_req_i.idx == pcht_pkg::IDX_CAP_PTR
		|=> periph_rdata_o[pcht_pkg::LAT_MSB:pcht_pkg::UPPER_LSB] == pcht_pkg::ZERO_UPPER)
		else $error("capability pointer upper bits nonzero on peripheral port");

	// ----------------------------------------
	// fixed fields of the latency/grant/interrupt word
	// ----------------------------------------
	lat_pci_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
		|=> pci_rdata_o[pcht_pkg::LAT_MSB:pcht_pkg::LAT_LSB] == pcht_pkg::MAX_LATENCY)
		else $error("max latency field nonzero on pci port");

	gnt_pci_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
		|=> pci_rdata_o[pcht_pkg::GNT_MSB:pcht_pkg::GNT_LSB] == pcht_pkg::MIN_GRANT)
		else $error("min grant field nonzero on pci port");

	lat_periph_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
		|=> periph_rdata_o[pcht_pkg::LAT_MSB:pcht_pkg::LAT_LSB] == pcht_pkg::MAX_LATENCY)
		else $error("max latency field nonzero on peripheral port");

	gnt_periph_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
		|=> periph_rdata_o[pcht_pkg::GNT_MSB:pcht_pkg::GNT_LSB] == pcht_pkg::MIN_GRANT)
		else $error("min grant field nonzero on peripheral port");

	pin_pci_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.rd && pci_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
		|=> pci_rdata_o[pcht_pkg::PIN_MSB:pcht_pkg::PIN_LSB] == pcht_pkg::INT_PIN_INTA)
		else $error("interrupt pin wrong on pci port");

	// ----------------------------------------
	// interrupt line storage
	// ----------------------------------------
	line_rb_periph_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.rd && periph_req_i.idx == pcht_pkg::IDX_LAT_GNT_INT
		|=> periph_rdata_o[pcht_pkg::LINE_MSB:pcht_pkg::LINE_LSB] == $past(int_line_o))
		else $error("line readback wrong on peripheral port");

	pci_we_decode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_line_we == hits_line(pci_req_i))
		else $error("pci line write enable wrong");

	periph_we_decode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_line_we == hits_line(periph_req_i))
		else $error("peripheral line write enable wrong");

	pci_lane_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.wr && !pci_req_i.be[pcht_pkg::LANE_LINE] && !hits_line(periph_req_i)
		|=> $stable(int_line_o))
		else $error("pci write without line lane changed line");

	periph_lane_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.wr && !periph_req_i.be[pcht_pkg::LANE_LINE] && !hits_line(pci_req_i)
		|=> $stable(int_line_o))
		else $error("peripheral write without line lane changed line");

	pci_rsvd_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		pci_req_i.wr && pci_req_i.idx != pcht_pkg::IDX_LAT_GNT_INT && !hits_line(periph_req_i)
		|=> $stable(int_line_o))
		else $error("pci write to fixed word changed line");

	periph_rsvd_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		periph_req_i.wr && periph_req_i.idx != pcht_pkg::IDX_LAT_GNT_INT
			&& !hits_line(pci_req_i)
		|=> $stable(int_line_o))
		else $error("peripheral write to fixed word changed line");

	collide_pci_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		hits_line(pci_req_i) && hits_line(periph_req_i)
		|=> int_line_o == $past(pci_req_i.wdata[pcht_pkg::LINE_MSB:pcht_pkg::LINE_LSB]))
		else $error("colliding writes did not keep pci value");

	// ----------------------------------------
	// reset
	// ----------------------------------------
	reset_rdata_a: assert property (@(posedge core_clk_i)
		$past(rst_i) |-> pci_rdata_o == pcht_pkg::ZERO_WORD
			&& periph_rdata_o == pcht_pkg::ZERO_WORD)
		else $error("read data not cleared by reset");

	reset_word_a: assert property (@(posedge core_clk_i)
		$past(rst_i) |-> {pcht_pkg::MAX_LATENCY, pcht_pkg::MIN_GRANT,
			pcht_pkg::INT_PIN_INTA, int_line_o} == pcht_pkg::LGI_RESET)
		else $error("interrupt word reset value wrong");

endmodule

// ----------------------------------------
// address decode and read mux for one port
// ----------------------------------------
module pcht_port_dec (
	// access from one port
	input wire pcht_pkg::pcht_req_t req_i,
	// stored interrupt line
	input wire logic [7:0] line_i,
	// decode results
	output logic [3:0] sel_o,
	output logic line_we_o,
	output logic [31:0] word_o
);

	// ----------------------------------------
	// word select
	// ----------------------------------------
	// an index outside this stretch selects nothing and so reads zero
	always_comb begin
		sel_o = '0;
		sel_o[pcht_pkg::SEL_RESERVED_A] = req_i.idx == pcht_pkg::IDX_RESERVED_A;
		sel_o[pcht_pkg::SEL_CAP_PTR] = req_i.idx == pcht_pkg::IDX_CAP_PTR;
		sel_o[pcht_pkg::SEL_RESERVED_B] = req_i.idx == pcht_pkg::IDX_RESERVED_B;
		sel_o[pcht_pkg::SEL_LAT_GNT_INT] = req_i.idx == pcht_pkg::IDX_LAT_GNT_INT;
	end

	// ----------------------------------------
	// read word
	// ----------------------------------------
	// reserved words need no term of their own: the zero default covers them
	always_comb begin
		word_o = pcht_pkg::ZERO_WORD;
		if (sel_o[pcht_pkg::SEL_CAP_PTR]) begin
			word_o = {pcht_pkg::ZERO_UPPER, pcht_pkg::CAP_OFFSET};
		end
		if (sel_o[pcht_pkg::SEL_LAT_GNT_INT]) begin
			word_o = {pcht_pkg::MAX_LATENCY, pcht_pkg::MIN_GRANT,
				pcht_pkg::INT_PIN_INTA, line_i};
		end
	end

	// ----------------------------------------
	// line write enable
	// ----------------------------------------
	// without the low byte lane a write to this word stores nothing
	assign line_we_o = req_i.wr && sel_o[pcht_pkg::SEL_LAT_GNT_INT]
		&& req_i.be[pcht_pkg::LANE_LINE];

endmodule

/* File: bench/pcht_host.sv */
// pci host model issuing configuration accesses
`timescale 1ns/1ns
module pcht_host (
	// clock
	input wire logic core_clk_i,
	// configuration access
	output pcht_pkg::pcht_req_t pci_req_o
);
	initial pci_req_o = '0;
	// one access per call, held for one edge; idle data is inverted so stale values never match
	task automatic xfer(input logic rd, input logic wr, input logic [5:0] idx,
		input logic [3:0] be, input logic [31:0] wd);
		@(negedge core_clk_i);
		pci_req_o = {rd, wr, idx, be, wd};
		@(negedge core_clk_i);
		pci_req_o = {2'b00, ~idx, be, ~wd};
	endtask
endmodule

/* File: bench/pcht_regs_tb.sv */
// self-checking bench for the config header tail
`timescale 1ns/1ns
module pcht_regs_tb;
	typedef struct packed {
		logic p;
		logic [5:0] idx;
		logic [3:0] be;
		logic [31:0] wd;
		logic [31:0] ex;
	} pcht_row_t;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	pcht_pkg::pcht_req_t pci_req, pp_req = '0;
	logic [31:0] pci_rd, pp_rd;
	logic [7:0] line;
	int bad_count = 0;
	int n_compared = 0;
	pcht_row_t rows [6] = '{
		'{1'b1, 6'hF, 4'h1, 32'hFFFFFF05, 32'h00000105},
		'{1'b0, 6'hF, 4'h1, 32'h12345677, 32'h00000177},
		'{1'b1, 6'hF, 4'hE, 32'hFFFFFF00, 32'h00000177},
		'{1'b0, 6'hC, 4'hF, 32'hFFFFFFFF, 32'h00000000},
		'{1'b1, 6'hD, 4'hF, 32'hFFFFFFFF, 32'h00000040},
		'{1'b0, 6'hE, 4'hF, 32'hFFFFFFFF, 32'h00000000}};
	initial forever #4 core_clk_i = ~core_clk_i;
	pcht_host u_pcht_host (.core_clk_i(core_clk_i), .pci_req_o(pci_req));
	pcht_regs u_pcht_regs (.core_clk_i(core_clk_i), .rst_i(rst_i), .pci_req_i(pci_req),
		.pci_rdata_o(pci_rd), .periph_req_i(pp_req), .periph_rdata_o(pp_rd), .int_line_o(line));
	task automatic check(input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, ex);
		end
	endtask
	task automatic pp(input logic rd, input logic wr, input logic [5:0] idx,
		input logic [3:0] be, input logic [31:0] wd);
		@(negedge core_clk_i);
		pp_req = {rd, wr, idx, be, wd};
		@(negedge core_clk_i);
		pp_req = {2'b00, ~idx, be, ~wd};
	endtask
	// one access through the given port: a write when wr is high, else a read
	task automatic acc(input logic p, input logic wr, input logic [5:0] idx,
		input logic [3:0] be, input logic [31:0] wd);
		if (p) u_pcht_host.xfer(~wr, wr, idx, be, wd);
		else pp(~wr, wr, idx, be, wd);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		conclude();
	end
	initial begin
		repeat (16) @(negedge core_clk_i);
		rst_i = 1'b0;
		acc(1'b1, 1'b0, 6'hF, 4'hF, 32'h0);
		check(pci_rd, 32'h00000100);
		foreach (rows[i]) begin
			acc(rows[i].p, 1'b1, rows[i].idx, rows[i].be, rows[i].wd);
			acc(~rows[i].p, 1'b0, rows[i].idx, 4'hF, 32'h0);
			check(rows[i].p ? pp_rd : pci_rd, rows[i].ex);
		end
		$display("table done");
		fork
			u_pcht_host.xfer(1'b0, 1'b1, 6'hF, 4'h1, 32'h000000AA);
			pp(1'b0, 1'b1, 6'hF, 4'h1, 32'h000000BB);
		join
		check({24'h0, line}, 32'h000000AA);
		$display("collision done");
		rst_i = 1'b1;
		@(negedge core_clk_i);
		rst_i = 1'b0;
		pp(1'b1, 1'b0, 6'hF, 4'hF, 32'h0);
		check(pp_rd, 32'h00000100);
		$display("reset done");
		conclude();
	end
endmodule
